// file: include/clic_pkg.sv
// Shared constants and types for the compare channel low-power and interrupt block
package clic_pkg;

    // ==========================================================
    // Widths
    localparam int CTRL_W = 16;
    localparam int TMR_W = 16;
    localparam int MODE_W = 3;

    // ==========================================================
    // Control word field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 2;
    localparam int CTRL_TSEL_BIT = 3;
    localparam int CTRL_SIDL_BIT = 13;

    // ==========================================================
    // Reset values and fixed figures
    localparam logic PIN_RESET = 1'b0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic DONE_RESET = 1'b0;
    localparam logic [TMR_W-1:0] DUTY_RESET = 16'h0000;
    localparam logic [TMR_W-1:0] DUTY_ZERO = 16'h0000;
    localparam logic TSEL_TIMER_A = 1'b0;
    localparam logic TSEL_TIMER_B = 1'b1;

    // ==========================================================
    // Channel modes
    typedef enum logic [MODE_W-1:0] {
        CLIC_MODE_OFF = 3'b000,
        CLIC_MODE_MATCH_LOW = 3'b001,
        CLIC_MODE_MATCH_HIGH = 3'b010,
        CLIC_MODE_MATCH_TOGGLE = 3'b011,
        CLIC_MODE_DUAL_SINGLE = 3'b100,
        CLIC_MODE_DUAL_CONT = 3'b101,
        CLIC_MODE_PWM = 3'b110,
        CLIC_MODE_PWM_FAULT = 3'b111
    } clic_mode_t;

endpackage

// file: hdl/clic_flag_cell.sv
// One sticky interrupt flag with its enable gate
`timescale 1ns/100ps
module clic_flag_cell (
    clk,
    rst,
    hold,
    set,
    clr,
    enable,
    flag,
    req
);
    import clic_pkg::*;

    input wire logic clk;
    input wire logic rst;
    input wire logic hold;
    input wire logic set;
    input wire logic clr;
    input wire logic enable;
    output logic flag;
    output logic req;

    typedef struct packed {
        logic flag;
        logic req;
    } clic_cell_t;

    clic_cell_t state_reg;
    clic_cell_t state_next;

    // ==========================================================
    // Next state: set beats clear so no event is lost
    always_comb begin
        state_next = state_reg;
        if (!hold) begin
            state_next.flag = set | (state_reg.flag & ~clr);
        end
        state_next.req = state_next.flag & enable;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{flag: FLAG_RESET, req: FLAG_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;
    assign req = state_reg.req;

    // ==========================================================
    // Checks
    AST_REQ_AND: assert property (@(posedge clk) disable iff (rst)
        ##1 (req == (flag && $past(enable)))) else $error("request is not flag AND enable");
    AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (rst)
        (flag && !clr) |=> flag) else $error("flag dropped without a clear");

endmodule

// file: hdl/clic_top.sv
// Output compare channel: sleep freeze, idle gating, waveform modes and interrupt flags
`timescale 1ns/100ps
module clic_top (
    clk,
    rst,
    cpu_sleep,
    cpu_idle,
    compare_control_reg,
    compare_value,
    compare_second_value,
    timer_a_count,
    timer_b_count,
    timer_a_period_reg,
    timer_b_period_reg,
    timer_a_inc,
    timer_b_inc,
    timer_a_on,
    timer_b_on,
    timer_a_stop_in_idle,
    timer_b_stop_in_idle,
    compare_irq_enable,
    timer_a_irq_enable,
    timer_b_irq_enable,
    compare_irq_flag_clr,
    timer_a_irq_flag_clr,
    timer_b_irq_flag_clr,
    compare_output_pin,
    compare_irq_flag,
    timer_a_irq_flag,
    timer_b_irq_flag,
    compare_irq_req,
    timer_a_irq_req,
    timer_b_irq_req
);
    import clic_pkg::*;

    input wire logic clk;
    input wire logic rst;
    input wire logic cpu_sleep;
    input wire logic cpu_idle;
    input wire logic [clic_pkg::CTRL_W-1:0] compare_control_reg;
    input wire logic [clic_pkg::TMR_W-1:0] compare_value;
    input wire logic [clic_pkg::TMR_W-1:0] compare_second_value;
    input wire logic [clic_pkg::TMR_W-1:0] timer_a_count;
    input wire logic [clic_pkg::TMR_W-1:0] timer_b_count;
    input wire logic [clic_pkg::TMR_W-1:0] timer_a_period_reg;
    input wire logic [clic_pkg::TMR_W-1:0] timer_b_period_reg;
    input wire logic timer_a_inc;
    input wire logic timer_b_inc;
    input wire logic timer_a_on;
    input wire logic timer_b_on;
    input wire logic timer_a_stop_in_idle;
    input wire logic timer_b_stop_in_idle;
    input wire logic compare_irq_enable;
    input wire logic timer_a_irq_enable;
    input wire logic timer_b_irq_enable;
    input wire logic compare_irq_flag_clr;
    input wire logic timer_a_irq_flag_clr;
    input wire logic timer_b_irq_flag_clr;
    output logic compare_output_pin;
    output logic compare_irq_flag;
    output logic timer_a_irq_flag;
    output logic timer_b_irq_flag;
    output logic compare_irq_req;
    output logic timer_a_irq_req;
    output logic timer_b_irq_req;

    // ==========================================================
    // Channel state
    typedef struct packed {
        logic pin;
        logic [TMR_W-1:0] duty;
        logic pulse_done;
        logic [MODE_W-1:0] mode_prev;
    } clic_state_t;

    clic_state_t state_reg;
    clic_state_t state_next;

    // ==========================================================
    // Decoded control and selected time base
    clic_mode_t mode;
    logic timebase_select;
    logic compare_stop_in_idle;
    logic [TMR_W-1:0] sel_count;
    logic [TMR_W-1:0] sel_period;
    logic sel_inc;
    logic sel_on;
    logic timebase_stop_in_idle;
    logic idle_ok;
    logic run;
    logic is_pwm;
    logic cmp_evt;
    logic cmp2_evt;
    logic per_evt;
    logic duty_evt;
    logic mode_chg;
    logic cmp_set;
    logic ta_set;
    logic tb_set;

    // Field extraction; first timer is the default at all-zero control
    always_comb begin
        mode = clic_mode_t'(compare_control_reg[CTRL_MODE_MSB:CTRL_MODE_LSB]);
        timebase_select = compare_control_reg[CTRL_TSEL_BIT];
        compare_stop_in_idle = compare_control_reg[CTRL_SIDL_BIT];
    end

    // Time base mux
    always_comb begin
        if (timebase_select == TSEL_TIMER_B) begin
            sel_count = timer_b_count;
            sel_period = timer_b_period_reg;
            sel_inc = timer_b_inc;
            sel_on = timer_b_on;
            timebase_stop_in_idle = timer_b_stop_in_idle;
        end else begin
            sel_count = timer_a_count;
            sel_period = timer_a_period_reg;
            sel_inc = timer_a_inc;
            sel_on = timer_a_on;
            timebase_stop_in_idle = timer_a_stop_in_idle;
        end
    end

    // Run gating: sleep stops everything, idle stops unless all three conditions hold
    always_comb begin
        idle_ok = !compare_stop_in_idle && sel_on && !timebase_stop_in_idle;
        run = !cpu_sleep && (!cpu_idle || idle_ok);
        is_pwm = (mode == CLIC_MODE_PWM) || (mode == CLIC_MODE_PWM_FAULT);
        cmp_evt = run && sel_inc && (sel_count == compare_value);
        cmp2_evt = run && sel_inc && (sel_count == compare_second_value);
        per_evt = run && sel_inc && (sel_count == sel_period);
        duty_evt = run && sel_inc && (sel_count == state_reg.duty);
        mode_chg = (mode != clic_mode_t'(state_reg.mode_prev));
    end

    // ==========================================================
    // Waveform and flag-set logic
    // Only the pin-affecting skeleton of each mode lives here; fault shut-off of the
    // last PWM mode is not modelled, it behaves as plain PWM.
    always_comb begin
        state_next = state_reg;
        cmp_set = 1'b0;
        ta_set = 1'b0;
        tb_set = 1'b0;
        if (!cpu_sleep) begin
            state_next.mode_prev = mode;
            case (mode)
                CLIC_MODE_MATCH_LOW: begin
                    if (cmp_evt) begin
                        state_next.pin = 1'b0;
                        cmp_set = 1'b1;
                    end
                end
                CLIC_MODE_MATCH_HIGH: begin
                    if (cmp_evt) begin
                        state_next.pin = 1'b1;
                        cmp_set = 1'b1;
                    end
                end
                CLIC_MODE_MATCH_TOGGLE: begin
                    if (cmp_evt) begin
                        state_next.pin = ~state_reg.pin;
                        cmp_set = 1'b1;
                    end
                end
                CLIC_MODE_DUAL_SINGLE: begin
                    // A change into this mode from another mode re-arms one pulse
                    if (mode_chg) begin
                        state_next.pulse_done = DONE_RESET;
                    end else if (!state_reg.pulse_done) begin
                        if (cmp_evt) begin
                            state_next.pin = 1'b1;
                        end
                        if (cmp2_evt) begin
                            state_next.pin = 1'b0;
                            state_next.pulse_done = 1'b1;
                            cmp_set = 1'b1;
                        end
                    end
                end
                CLIC_MODE_DUAL_CONT: begin
                    if (cmp_evt) begin
                        state_next.pin = 1'b1;
                    end
                    if (cmp2_evt) begin
                        state_next.pin = 1'b0;
                        cmp_set = 1'b1;
                    end
                end
                CLIC_MODE_PWM, CLIC_MODE_PWM_FAULT: begin
                    // Period end reloads duty; a zero duty keeps the pin low,
                    // a duty above the period never matches so the pin stays high
                    if (per_evt) begin
                        state_next.duty = compare_second_value;
                        state_next.pin = (compare_second_value != DUTY_ZERO);
                        ta_set = (timebase_select == TSEL_TIMER_A);
                        tb_set = (timebase_select == TSEL_TIMER_B);
                    end else if (duty_evt) begin
                        state_next.pin = 1'b0;
                    end
                end
                default: begin
                    // Channel off: pin keeps its level
                end
            endcase
            if (is_pwm) begin
                cmp_set = 1'b0;
            end
        end
    end

    // ==========================================================
    // State register; sleep simply re-registers the same copy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{pin: PIN_RESET, duty: DUTY_RESET, pulse_done: DONE_RESET,
                           mode_prev: CLIC_MODE_OFF};
        end else begin
            state_reg <= state_next;
        end
    end

    assign compare_output_pin = state_reg.pin;

    // ==========================================================
    // Interrupt flags, one cell per source
    clic_flag_cell u_cmp_flag (
        .clk(clk),
        .rst(rst),
        .hold(cpu_sleep),
        .set(cmp_set),
        .clr(compare_irq_flag_clr),
        .enable(compare_irq_enable),
        .flag(compare_irq_flag),
        .req(compare_irq_req)
    );

    clic_flag_cell u_ta_flag (
        .clk(clk),
        .rst(rst),
        .hold(cpu_sleep),
        .set(ta_set),
        .clr(timer_a_irq_flag_clr),
        .enable(timer_a_irq_enable),
        .flag(timer_a_irq_flag),
        .req(timer_a_irq_req)
    );

    clic_flag_cell u_tb_flag (
        .clk(clk),
        .rst(rst),
        .hold(cpu_sleep),
        .set(tb_set),
        .clr(timer_b_irq_flag_clr),
        .enable(timer_b_irq_enable),
        .flag(timer_b_irq_flag),
        .req(timer_b_irq_req)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_sleep_entry;
        !cpu_sleep ##1 cpu_sleep;
    endsequence

    sequence s_wake;
        cpu_sleep ##1 !cpu_sleep;
    endsequence

    // The level just before sleep is the one shown at the first sleeping edge;
    // an event taken on the last awake edge may still have moved it
    AST_SLEEP_PIN_HOLD: assert property (s_sleep_entry |=>
        (compare_output_pin == $past(compare_output_pin))) else $error("pin moved on entering sleep");
    AST_SLEEP_FREEZE: assert property (cpu_sleep |=>
        ($stable(compare_irq_flag) && $stable(timer_a_irq_flag) && $stable(timer_b_irq_flag)))
        else $error("flag changed during sleep");
    AST_WAKE_RESUME: assert property (s_wake |->
        ($stable(state_reg.duty) && $stable(compare_output_pin))) else $error("state lost over sleep");
    AST_IDLE_STOP: assert property ((cpu_idle && !idle_ok && !cpu_sleep) |=>
        $stable(compare_output_pin)) else $error("channel ran while stopped in idle");
    AST_CMP_FLAG_SET: assert property ((!cpu_sleep && !cpu_idle && timer_a_inc && !timebase_select
        && mode == CLIC_MODE_MATCH_TOGGLE && timer_a_count == compare_value) |=>
        (compare_irq_flag && compare_output_pin != $past(compare_output_pin))) else $error("match missed");
    AST_CMP_REQ_GATE: assert property (compare_irq_req |->
        (compare_irq_flag && $past(compare_irq_enable))) else $error("compare request without enable");
    AST_PWM_TIMER_A: assert property ((is_pwm && per_evt && timebase_select == TSEL_TIMER_A) |=>
        (timer_a_irq_flag && !$past(tb_set))) else $error("timer A flag not set");
    AST_PWM_TIMER_B: assert property ((is_pwm && per_evt && timebase_select == TSEL_TIMER_B) |=>
        timer_b_irq_flag) else $error("timer B flag not set");
    AST_PWM_REQ_GATE: assert property (timer_a_irq_req |->
        $past(timer_a_irq_enable)) else $error("timer request without enable");
    AST_PWM_NO_CMP: assert property ((is_pwm && !compare_irq_flag) |=>
        !compare_irq_flag) else $error("compare flag set in PWM");
    AST_PWM_PERIOD: assert property ((is_pwm && per_evt) |=>
        (compare_output_pin == ($past(compare_second_value) != DUTY_ZERO))) else $error("period edge wrong");

endmodule

// file: verification/clic_pin_load.sv
// Load on the compare output pin: counts the rising edges the far side sees
`timescale 1ns/100ps
module clic_pin_load (
    clk,
    rst,
    pin,
    rise_count
);
    input wire logic clk;
    input wire logic rst;
    input wire logic pin;
    output logic [7:0] rise_count;
    logic last_reg;
    // ==========
    // Edge counter; a pin frozen in sleep must leave it still
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_reg <= 1'b0;
            rise_count <= 8'h00;
        end else begin
            last_reg <= pin;
            if (pin && !last_reg) begin
                rise_count <= rise_count + 8'h01;
            end
        end
    end
endmodule

// file: verification/clic_top_tb_top.sv
// Self-checking bench for compare channel sleep, idle and interrupt behaviour
`timescale 1ns/100ps
module clic_top_tb_top;
    import clic_pkg::*;
    logic clk, rst, cpu_sleep, cpu_idle, timer_a_inc, timer_b_inc, timer_a_on, timer_b_on;
    logic timer_a_stop_in_idle, timer_b_stop_in_idle, compare_irq_enable, timer_a_irq_enable, timer_b_irq_enable;
    logic compare_irq_flag_clr, timer_a_irq_flag_clr, timer_b_irq_flag_clr;
    logic [15:0] compare_control_reg, compare_value, compare_second_value, timer_a_count, timer_b_count;
    logic [15:0] timer_a_period_reg, timer_b_period_reg;
    logic compare_output_pin, compare_irq_flag, timer_a_irq_flag, timer_b_irq_flag;
    logic compare_irq_req, timer_a_irq_req, timer_b_irq_req;
    logic [7:0] rise_count;
    int errors = 0;
    int samples_checked = 0;
    // ==========
    // Clock, design and pin load
    always #10 clk = ~clk;
    clic_top u_clic_top (
        .clk(clk),
        .rst(rst),
        .cpu_sleep(cpu_sleep),
        .cpu_idle(cpu_idle),
        .compare_control_reg(compare_control_reg),
        .compare_value(compare_value),
        .compare_second_value(compare_second_value),
        .timer_a_count(timer_a_count),
        .timer_b_count(timer_b_count),
        .timer_a_period_reg(timer_a_period_reg),
        .timer_b_period_reg(timer_b_period_reg),
        .timer_a_inc(timer_a_inc),
        .timer_b_inc(timer_b_inc),
        .timer_a_on(timer_a_on),
        .timer_b_on(timer_b_on),
        .timer_a_stop_in_idle(timer_a_stop_in_idle),
        .timer_b_stop_in_idle(timer_b_stop_in_idle),
        .compare_irq_enable(compare_irq_enable),
        .timer_a_irq_enable(timer_a_irq_enable),
        .timer_b_irq_enable(timer_b_irq_enable),
        .compare_irq_flag_clr(compare_irq_flag_clr),
        .timer_a_irq_flag_clr(timer_a_irq_flag_clr),
        .timer_b_irq_flag_clr(timer_b_irq_flag_clr),
        .compare_output_pin(compare_output_pin),
        .compare_irq_flag(compare_irq_flag),
        .timer_a_irq_flag(timer_a_irq_flag),
        .timer_b_irq_flag(timer_b_irq_flag),
        .compare_irq_req(compare_irq_req),
        .timer_a_irq_req(timer_a_irq_req),
        .timer_b_irq_req(timer_b_irq_req)
    );
    clic_pin_load u_clic_pin_load (.clk(clk), .rst(rst), .pin(compare_output_pin), .rise_count(rise_count));
    // ==========
    // Shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One increment pulse; outputs are read just after the edge that takes it
    task automatic ev(input logic on_b, input logic [15:0] cnt);
        @(posedge clk);
        timer_a_count <= cnt;
        timer_b_count <= cnt;
        timer_a_inc <= !on_b;
        timer_b_inc <= on_b;
        @(posedge clk);
        timer_a_inc <= 1'b0;
        timer_b_inc <= 1'b0;
        #1;
    endtask
    task automatic clear_all();
        @(posedge clk);
        {compare_irq_flag_clr, timer_a_irq_flag_clr, timer_b_irq_flag_clr} <= 3'b111;
        @(posedge clk);
        {compare_irq_flag_clr, timer_a_irq_flag_clr, timer_b_irq_flag_clr} <= 3'b000;
        #1;
    endtask
    task automatic ctl(input logic [15:0] v);
        @(posedge clk);
        compare_control_reg <= v;
    endtask
    // ==========
    // Scenarios
    task automatic t_reset();
        @(posedge clk);
        #1;
        check("outputs", {compare_output_pin, compare_irq_flag, timer_a_irq_flag, timer_b_irq_flag,
            compare_irq_req, timer_a_irq_req, timer_b_irq_req}, 16'h0000);
    endtask
    task automatic t_match();
        logic [2:0] modes [3] = '{3'b010, 3'b001, 3'b011};
        logic exp_pin [3] = '{1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 3; i++) begin
            ctl({13'h0000, modes[i]});
            clear_all();
            ev(1'b0, 16'h0010);
            check("match pin", compare_output_pin, exp_pin[i]);
            check("match flag", compare_irq_flag, 1'b1);
            check("match req", compare_irq_req, 1'b1);
        end
        ev(1'b0, 16'h0011);
        check("miss pin", compare_output_pin, 1'b1);
        check("sticky flag", compare_irq_flag, 1'b1);
        clear_all();
        check("cleared", {compare_irq_flag, compare_irq_req}, 2'b00);
        @(posedge clk);
        compare_irq_enable <= 1'b0;
        ev(1'b0, 16'h0010);
        check("masked", {compare_output_pin, compare_irq_flag, compare_irq_req}, 3'b010);
        @(posedge clk);
        compare_irq_enable <= 1'b1;
        @(posedge clk);
        #1;
        check("unmasked req", compare_irq_req, 1'b1);
    endtask
    // Two toggles in sleep would bring the pin back high, so the edge count guards it
    task automatic t_sleep();
        logic [7:0] rises;
        ev(1'b0, 16'h0010);
        @(posedge clk);
        cpu_sleep <= 1'b1;
        #1;
        rises = rise_count;
        ev(1'b0, 16'h0010);
        ev(1'b0, 16'h0010);
        clear_all();
        check("sleep hold", {compare_output_pin, compare_irq_flag}, 2'b11);
        check("sleep edges", rise_count, rises);
        @(posedge clk);
        cpu_sleep <= 1'b0;
        ev(1'b0, 16'h0010);
        check("wake resume", compare_output_pin, 1'b0);
        clear_all();
    endtask
    task automatic t_idle();
        logic [2:0] blk [3] = '{3'b110, 3'b000, 3'b011};
        @(posedge clk);
        cpu_idle <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            compare_control_reg <= {2'b00, blk[i][2], 13'h0003};
            timer_a_on <= blk[i][1];
            timer_a_stop_in_idle <= blk[i][0];
            ev(1'b0, 16'h0010);
            check("idle blocked", {compare_output_pin, compare_irq_flag}, 2'b00);
        end
        @(posedge clk);
        compare_control_reg <= 16'h000b;
        timer_a_stop_in_idle <= 1'b0;
        timer_b_on <= 1'b0;
        ev(1'b1, 16'h0010);
        check("idle timer b off", compare_output_pin, 1'b0);
        @(posedge clk);
        compare_control_reg <= 16'h0003;
        ev(1'b0, 16'h0010);
        check("idle run", {compare_output_pin, compare_irq_flag}, 2'b11);
        @(posedge clk);
        cpu_idle <= 1'b0;
        timer_b_on <= 1'b1;
        clear_all();
    endtask
    task automatic t_dual();
        ctl(16'h0005);
        ev(1'b0, 16'h0010);
        check("dual rise", {compare_output_pin, compare_irq_flag}, 2'b10);
        ev(1'b0, 16'h0020);
        check("dual fall", {compare_output_pin, compare_irq_flag}, 2'b01);
        ev(1'b0, 16'h0010);
        check("dual again", compare_output_pin, 1'b1);
        // Single pulse: armed by the mode change, then done after one fall
        ctl(16'h0004);
        clear_all();
        ev(1'b0, 16'h0020);
        check("single fall", {compare_output_pin, compare_irq_flag}, 2'b01);
        ev(1'b0, 16'h0010);
        check("single once", compare_output_pin, 1'b0);
        clear_all();
    endtask
    task automatic t_pwm();
        @(posedge clk);
        compare_control_reg <= 16'h0006;
        compare_second_value <= 16'h0004;
        timer_a_irq_enable <= 1'b1;
        ev(1'b0, 16'h0009);
        check("pwm period", {compare_output_pin, timer_a_irq_flag, timer_a_irq_req}, 3'b111);
        ev(1'b0, 16'h0004);
        check("pwm duty", compare_output_pin, 1'b0);
        ev(1'b0, 16'h0010);
        check("pwm compare flag", {compare_irq_flag, compare_irq_req}, 2'b00);
        @(posedge clk);
        timer_a_irq_enable <= 1'b0;
        @(posedge clk);
        #1;
        check("pwm masked", {timer_a_irq_flag, timer_a_irq_req}, 2'b10);
        @(posedge clk);
        compare_control_reg <= 16'h000f;
        timer_b_irq_enable <= 1'b1;
        ev(1'b1, 16'h0007);
        check("pwm timer b", {compare_output_pin, timer_b_irq_flag, timer_b_irq_req, compare_irq_flag},
            4'b1110);
        @(posedge clk);
        compare_second_value <= 16'h0000;
        ev(1'b1, 16'h0007);
        check("pwm zero duty", compare_output_pin, 1'b0);
        clear_all();
        check("timer flags cleared", {timer_a_irq_flag, timer_b_irq_flag, timer_b_irq_req}, 3'b000);
    endtask
    // ==========
    // Main sequence and watchdog
    initial begin
        {clk, cpu_sleep, cpu_idle, timer_a_inc, timer_b_inc, timer_a_stop_in_idle, timer_b_stop_in_idle} = '0;
        {compare_irq_flag_clr, timer_a_irq_flag_clr, timer_b_irq_flag_clr} = '0;
        {timer_a_irq_enable, timer_b_irq_enable} = '0;
        {timer_a_on, timer_b_on, compare_irq_enable} = 3'b111;
        {compare_control_reg, timer_a_count, timer_b_count} = '0;
        compare_value = 16'h0010;
        compare_second_value = 16'h0020;
        timer_a_period_reg = 16'h0009;
        timer_b_period_reg = 16'h0007;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_match();
        t_sleep();
        t_idle();
        t_dual();
        t_pwm();
        close_out();
    end
    // Whole run is about a hundred cycles; this is far beyond it
    initial begin
        #100000;
        errors++;
        close_out();
    end
endmodule
